/* pll_freq_consts.svh */
// Register offsets, field positions, reset values and timing constants of the frequency-program block
`ifndef PLL_FREQ_CONSTS_SVH
`define PLL_FREQ_CONSTS_SVH

`define OFS_CPU_N_LO        8'h0f
`define OFS_CPU_N_HI_M      8'h10
`define OFS_PCIE_NUM        8'h11
`define OFS_FREQ_CTRL       8'h12

`define CTRL_GLIDE_MAN_BIT  7
`define CTRL_GLIDE_SEL_BIT  6
`define CTRL_PCIE_EN_BIT    5
`define CTRL_CPU_EN_BIT     4
`define CTRL_RW_MASK        8'hf0

`define CPU_NHI_BIT         7

`define RST_BYTE            8'h00
`define RST_CPU_N           9'h000
`define RST_CPU_M           7'h00

`define SLEEP_SYNC_EDGES    2
`define GLIDE_STEP_NS       667
`define CLK_PERIOD_NS       10
`define GLIDE_STEP_CYC      ((`GLIDE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* pll_freq_pkg.sv */
// Types shared by the frequency-program block
package pll_freq_pkg;
    typedef enum logic [1:0] {
        PWR_WAIT_GOOD,
        PWR_RUN,
        PWR_PARK,
        PWR_OFF
    } pwr_state_e;
endpackage

/* glide_ramp.sv */
// Glide ramp: steps a target word toward its goal one count per step period
`timescale 1ns/1ps
`default_nettype none
`include "pll_freq_consts.svh"

module glide_ramp #(
    parameter int W         = 16,
    parameter int STEP_CYC  = `GLIDE_STEP_CYC
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_nrst,
    // Control
    input  wire logic         i_active,
    input  wire logic [W-1:0] i_goal,
    // Result
    output logic      [W-1:0] o_value,
    output logic              o_busy
);
    localparam int CW = $clog2(STEP_CYC + 1);
    logic [CW-1:0] tick_r;
    logic [W-1:0]  value_r;
    wire           tick_done = (tick_r == CW'(STEP_CYC - 1));
    wire           differ    = (value_r != i_goal);
    wire           go_up     = (value_r < i_goal);

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_r <= '0;
        end else if (!i_active || !differ || tick_done) begin
            tick_r <= '0;
        end else begin
            tick_r <= tick_r + CW'(1);
        end
    end

    // Without the glide the value jumps; with it one count per step
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            value_r <= '0;
        end else if (!i_active) begin
            value_r <= i_goal;
        end else if (differ && tick_done) begin
            value_r <= go_up ? value_r + W'(1) : value_r - W'(1);
        end
    end

    assign o_value = value_r;
    assign o_busy  = i_active && differ;
endmodule // glide_ramp

`default_nettype wire

/* pll_freq_program_powerdown.sv */
// Frequency-program, glide assignment and sleep control of the clock synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "pll_freq_consts.svh"

// Behaviour
// (RL1) Eight-bit PCIe numerator register, reset zero
// (RL2) Manual glide mode: software names owner PLL
// (RL3) Owner select: 0 CPU, 1 reference PLL
// (RL4) Bit 5 enables PCIe programmable frequency
// (RL5) Bit 4 enables CPU programmable frequency
// (RL6) Frequency equals gear times N over M
// (RL7) Gear taken from frequency-select straps
// (RL8) PCIe denominator fixed, only N writable
// (RL9) Host rewrites N with M, never M alone
// (RL10) Host loads dividers before setting enable
// (RL11) CPU N nine bits, M seven bits
// (RL12) Shared glide ramps changes slowly, glitch-free
// (RL13) Auto mode hands glide to overclocked PLL
// (RL14) PLL without glide still changes frequency
// (RL15) Host avoids enable plus both N writes
// (RL16) Restore bit 0: sleep forces cold reset
// (RL17) Restore bit 1: configuration kept over sleep
// (RL18) Management mode blocks sleep-triggered reset
// (RL19) Pin is power-good, then sleep request
// (RL20) Sleep request synchronised before acting
// (RL21) Clocks parked low before oscillators stop
// (RL22) Releasing sleep wakes outputs again
// (RL23) Sleep taken after two complement-clock edges
// (RL24) Dividers reach PLL only after write ends
module pll_freq_program_powerdown #(
    parameter int NW       = 9,
    parameter int MW       = 7,
    parameter int PW       = 8,
    parameter int GW       = 8,
    parameter int SELW     = 5,
    parameter logic [MW-1:0] PCIE_FIXED_M = 7'h01
) (
    // Clock and reset
    input  wire logic            i_clk_sys,
    input  wire logic            i_nrst,
    // Configuration byte port from the management bus
    input  wire logic            i_wr_en,
    input  wire logic [7:0]      i_addr,
    input  wire logic [7:0]      i_wdata,
    input  wire logic            i_wr_done,
    output logic      [7:0]      o_rdata,
    // Byte 0 policy bits
    input  wire logic            i_keep_config_on_sleep,
    input  wire logic            i_mgmt_mode,
    // Straps and gear lookup
    input  wire logic [SELW-1:0] i_frequency_select_straps,
    input  wire logic [GW-1:0]   i_gear_cpu,
    input  wire logic [GW-1:0]   i_gear_refclk,
    // Pins
    input  wire logic            i_sleep_pin_n,
    input  wire logic            i_processor_clock_complement,
    // PLL control
    output logic      [SELW-1:0] o_gear_select,
    output logic [GW+NW-1:0]     o_cpu_freq_scaled,
    output logic      [MW-1:0]   o_cpu_freq_denominator,
    output logic [GW+NW-1:0]     o_refclk_freq_scaled,
    output logic      [MW-1:0]   o_refclk_freq_denominator,
    output logic                 o_cpu_prog_active,
    output logic                 o_refclk_prog_active,
    output logic                 o_glide_to_refclk,
    output logic                 o_glide_busy,
    // Power control
    output logic                 o_power_good_seen,
    output logic                 o_clocks_park_low,
    output logic                 o_osc_enable,
    output logic                 o_cold_reset
);
    localparam int FW = GW + NW;

    // Two-flop synchronisers for the pins
    logic [1:0] pin_sync_r;
    logic [1:0] cc_sync_r;
    logic       cc_prev_r;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_sync_r <= 2'h0;
            cc_sync_r  <= 2'h0;
            cc_prev_r  <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], i_sleep_pin_n}; // RL20
            cc_sync_r  <= {cc_sync_r[0], i_processor_clock_complement};
            cc_prev_r  <= cc_sync_r[1];
        end
    end
    wire pin_level = pin_sync_r[1];
    wire cc_rise   = cc_sync_r[1] && !cc_prev_r;
    wire cc_fall   = !cc_sync_r[1] && cc_prev_r;

    // Shadow (written) registers and live (applied) registers
    logic [NW-1:0] cpu_n_sh_r;
    logic [MW-1:0] cpu_m_sh_r;
    logic [PW-1:0] pcie_n_sh_r;
    logic [7:0]    ctrl_sh_r;
    logic [NW-1:0] cpu_n_r;
    logic [MW-1:0] cpu_m_r;
    logic [PW-1:0] pcie_n_r;
    logic [7:0]    ctrl_r;
    logic          cfg_reset;

    wire wr_cpu_lo = i_wr_en && (i_addr == `OFS_CPU_N_LO);
    wire wr_cpu_hi = i_wr_en && (i_addr == `OFS_CPU_N_HI_M);
    wire wr_pcie   = i_wr_en && (i_addr == `OFS_PCIE_NUM);
    wire wr_ctrl   = i_wr_en && (i_addr == `OFS_FREQ_CTRL);

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cpu_n_sh_r  <= `RST_CPU_N; // RL11
            cpu_m_sh_r  <= `RST_CPU_M; // RL11
            pcie_n_sh_r <= PW'(`RST_BYTE); // RL1
            ctrl_sh_r   <= `RST_BYTE; // RL4 RL5
        end else if (cfg_reset) begin
            cpu_n_sh_r  <= `RST_CPU_N; // RL16
            cpu_m_sh_r  <= `RST_CPU_M;
            pcie_n_sh_r <= PW'(`RST_BYTE);
            ctrl_sh_r   <= `RST_BYTE;
        end else begin
            if (wr_cpu_lo) begin
                cpu_n_sh_r[7:0] <= i_wdata;
            end
            if (wr_cpu_hi) begin
                cpu_n_sh_r[NW-1] <= i_wdata[`CPU_NHI_BIT];
                cpu_m_sh_r       <= i_wdata[MW-1:0];
            end
            if (wr_pcie) begin
                pcie_n_sh_r <= i_wdata[PW-1:0]; // RL1
            end
            if (wr_ctrl) begin
                ctrl_sh_r <= i_wdata & `CTRL_RW_MASK;
            end
        end
    end

    // Whole block write is applied at once when the transfer ends
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cpu_n_r  <= `RST_CPU_N;
            cpu_m_r  <= `RST_CPU_M;
            pcie_n_r <= PW'(`RST_BYTE);
            ctrl_r   <= `RST_BYTE;
        end else if (cfg_reset) begin
            cpu_n_r  <= `RST_CPU_N;
            cpu_m_r  <= `RST_CPU_M;
            pcie_n_r <= PW'(`RST_BYTE);
            ctrl_r   <= `RST_BYTE;
        end else if (i_wr_done) begin
            cpu_n_r  <= cpu_n_sh_r; // RL24
            cpu_m_r  <= cpu_m_sh_r; // RL9
            pcie_n_r <= pcie_n_sh_r; // RL24
            ctrl_r   <= ctrl_sh_r; // RL10
        end
    end

    // Readback of the shadow bytes, so a byte can be checked before the block ends
    wire [7:0] rd_cpu_lo = cpu_n_sh_r[7:0];
    wire [7:0] rd_cpu_hi = {cpu_n_sh_r[NW-1], cpu_m_sh_r};
    wire [7:0] rd_pcie   = 8'(pcie_n_sh_r);
    wire [7:0] rd_sel    = (i_addr == `OFS_CPU_N_LO)   ? rd_cpu_lo :
                           (i_addr == `OFS_CPU_N_HI_M) ? rd_cpu_hi :
                           (i_addr == `OFS_PCIE_NUM)   ? rd_pcie   :
                           (i_addr == `OFS_FREQ_CTRL)  ? ctrl_sh_r : `RST_BYTE;

    // Read data is registered: it follows the address one clock later
    logic [7:0] rdata_r;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r <= `RST_BYTE;
        end else begin
            rdata_r <= rd_sel;
        end
    end
    assign o_rdata = rdata_r;

    wire glide_manual = ctrl_r[`CTRL_GLIDE_MAN_BIT];
    wire glide_sel    = ctrl_r[`CTRL_GLIDE_SEL_BIT];
    wire pcie_en      = ctrl_r[`CTRL_PCIE_EN_BIT]; // RL4
    wire cpu_en       = ctrl_r[`CTRL_CPU_EN_BIT]; // RL5

    // Gear times numerator; both PLLs use the same product form
    function automatic logic [FW-1:0] scale(input logic [GW-1:0] g, input logic [NW-1:0] n);
        scale = FW'(g) * FW'(n);
    endfunction

    wire [FW-1:0] cpu_goal  = scale(i_gear_cpu, cpu_n_r); // RL6
    wire [FW-1:0] pcie_goal = scale(i_gear_refclk, NW'(pcie_n_r)); // RL6

    // Glide ownership: auto follows the most recent overclock request
    logic auto_owner_r;
    logic cpu_en_prev_r;
    logic pcie_en_prev_r;
    logic [FW-1:0] cpu_goal_prev_r;
    logic [FW-1:0] pcie_goal_prev_r;
    // A PLL claims the glide when its enable rises or its goal moves while it is enabled; the CPU PLL wins when both do so in one cycle
    wire cpu_change  = (cpu_en && !cpu_en_prev_r) || (cpu_en && cpu_goal != cpu_goal_prev_r);
    wire pcie_change = (pcie_en && !pcie_en_prev_r) || (pcie_en && pcie_goal != pcie_goal_prev_r);
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            auto_owner_r     <= 1'b0;
            cpu_en_prev_r    <= 1'b0;
            pcie_en_prev_r   <= 1'b0;
            cpu_goal_prev_r  <= '0;
            pcie_goal_prev_r <= '0;
        end else begin
            cpu_en_prev_r    <= cpu_en;
            pcie_en_prev_r   <= pcie_en;
            cpu_goal_prev_r  <= cpu_goal;
            pcie_goal_prev_r <= pcie_goal;
            if (pcie_change && !cpu_change) begin
                auto_owner_r <= 1'b1; // RL13
            end else if (cpu_change) begin
                auto_owner_r <= 1'b0; // RL13
            end
        end
    end

    wire owner_refclk = glide_manual ? glide_sel : auto_owner_r; // RL2 RL3
    wire cpu_glide    = cpu_en && !owner_refclk;
    wire pcie_glide   = pcie_en && owner_refclk;

    logic [FW-1:0] glide_value;
    logic          glide_busy;
    wire  [FW-1:0] glide_goal = owner_refclk ? pcie_goal : cpu_goal;
    glide_ramp #(
        .W        (FW),
        .STEP_CYC (`GLIDE_STEP_CYC)
    ) u_glide (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_active  (cpu_glide || pcie_glide), // RL12
        .i_goal    (glide_goal),
        .o_value   (glide_value),
        .o_busy    (glide_busy)
    );

    // Non-owner takes the new value directly
    logic [FW-1:0] cpu_out_r;
    logic [FW-1:0] pcie_out_r;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cpu_out_r  <= '0;
            pcie_out_r <= '0;
        end else begin
            cpu_out_r  <= cpu_glide ? glide_value : cpu_goal; // RL14
            pcie_out_r <= pcie_glide ? glide_value : pcie_goal; // RL14
        end
    end

    // Power-good then sleep sequence
    pll_freq_pkg::pwr_state_e state_r;
    pll_freq_pkg::pwr_state_e state_nxt;
    logic [1:0] low_cnt_r;
    logic       cold_r;
    // Count of synchronised complement-clock rises while the request is low
    wire sleep_seen = (low_cnt_r == 2'(`SLEEP_SYNC_EDGES)); // RL23
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pll_freq_pkg::PWR_WAIT_GOOD: if (pin_level) state_nxt = pll_freq_pkg::PWR_RUN; // RL19
            pll_freq_pkg::PWR_RUN:       if (sleep_seen) state_nxt = pll_freq_pkg::PWR_PARK;
            pll_freq_pkg::PWR_PARK:      if (pin_level) state_nxt = pll_freq_pkg::PWR_RUN;
                                         else if (cc_fall) state_nxt = pll_freq_pkg::PWR_OFF; // RL23
            pll_freq_pkg::PWR_OFF:       if (pin_level) state_nxt = pll_freq_pkg::PWR_RUN; // RL22
            default:                     state_nxt = pll_freq_pkg::PWR_WAIT_GOOD;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r   <= pll_freq_pkg::PWR_WAIT_GOOD;
            low_cnt_r <= 2'h0;
            cold_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r != pll_freq_pkg::PWR_RUN || pin_level) begin
                low_cnt_r <= 2'h0;
            end else if (cc_rise && !sleep_seen) begin
                low_cnt_r <= low_cnt_r + 2'h1; // RL23
            end
            // Only the run-to-park step pulses, so one sleep resets once
            cold_r <= (state_r == pll_freq_pkg::PWR_RUN) && sleep_seen &&
                      !i_keep_config_on_sleep && !i_mgmt_mode; // RL16 RL17 RL18
        end
    end
    assign cfg_reset = cold_r;

    assign o_gear_select             = i_frequency_select_straps; // RL7
    assign o_cpu_freq_scaled         = cpu_out_r;
    assign o_cpu_freq_denominator    = cpu_m_r; // RL6
    assign o_refclk_freq_scaled      = pcie_out_r;
    assign o_refclk_freq_denominator = PCIE_FIXED_M; // RL8
    assign o_cpu_prog_active         = cpu_en;
    assign o_refclk_prog_active      = pcie_en;
    assign o_glide_to_refclk         = owner_refclk;
    assign o_glide_busy              = glide_busy;
    assign o_power_good_seen         = (state_r != pll_freq_pkg::PWR_WAIT_GOOD);
    assign o_clocks_park_low         = (state_r != pll_freq_pkg::PWR_RUN); // RL21
    assign o_osc_enable              = (state_r != pll_freq_pkg::PWR_OFF); // RL21
    assign o_cold_reset              = cold_r;
endmodule // pll_freq_program_powerdown

`default_nettype wire

/* pll_freq_props.sv */
// Port-level assertions of the frequency-program and sleep block
`timescale 1ns/1ps
`default_nettype none
module pll_freq_props (
    // Clock, reset and inputs watched
    input wire logic       i_clk_sys, i_nrst, i_wr_done, i_keep_config_on_sleep, i_mgmt_mode, i_sleep_pin_n,
    input wire logic [7:0] i_addr,
    input wire logic [4:0] i_frequency_select_straps,
    // Outputs watched
    input wire logic [7:0] o_rdata,
    input wire logic [4:0] o_gear_select,
    input wire logic [6:0] o_cpu_freq_denominator,
    input wire logic       o_cpu_prog_active, o_cold_reset, o_power_good_seen, o_clocks_park_low,
    input wire logic       o_osc_enable, o_glide_busy
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    chk_gear_follows: assert property (o_gear_select == i_frequency_select_straps)
        else $error("gear select differs from straps");
    chk_ctrl_reserved: assert property (i_addr == 8'h12 |=> o_rdata[3:0] == 4'h0)
        else $error("reserved control bits read nonzero");
    chk_enable_on_done: assert property ($changed(o_cpu_prog_active) |-> $past(i_wr_done) || $past(o_cold_reset) || o_cold_reset)
        else $error("cpu enable changed without write end");
    chk_m_on_done: assert property ($changed(o_cpu_freq_denominator) |-> $past(i_wr_done) || $past(o_cold_reset) || o_cold_reset)
        else $error("cpu denominator changed without write end");
    chk_park_before_good: assert property (!o_power_good_seen |-> o_clocks_park_low)
        else $error("clocks running before power good");
    chk_osc_after_park: assert property ($fell(o_osc_enable) |-> $past(o_clocks_park_low))
        else $error("oscillator stopped before clocks parked");
    chk_reset_policy: assert property (o_cold_reset |-> !$past(i_keep_config_on_sleep) && !$past(i_mgmt_mode))
        else $error("cold reset against policy bits");
    chk_reset_pulse: assert property (o_cold_reset |=> !o_cold_reset)
        else $error("cold reset longer than one cycle");
    chk_sleep_synced: assert property ($rose(o_clocks_park_low) |-> $past(i_sleep_pin_n, 4) == 1'b0)
        else $error("park without synchronised sleep request");
    chk_wake_run: assert property ((o_power_good_seen && i_sleep_pin_n) [*5] |-> !o_clocks_park_low)
        else $error("clocks still parked after wake");
    cover property (o_cold_reset);
    cover property ($fell(o_osc_enable));
    cover property ($fell(o_glide_busy));
endmodule // pll_freq_props
`default_nettype wire

/* smbus_host_model.sv */
// Management-bus host model that writes configuration bytes
`timescale 1ns/1ps
`default_nettype none
`include "pll_freq_consts.svh"
module smbus_host_model (
    input  wire logic       i_clk_sys,
    output logic            o_wr_en   = 1'b0,
    output logic            o_wr_done = 1'b0,
    output logic      [7:0] o_addr    = 8'h00,
    output logic      [7:0] o_wdata   = 8'h00
);
    // Released data lines show the inverse of the last byte
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_wr_en = 1'b1;
        o_addr  = a;
        o_wdata = d;
        @(negedge i_clk_sys);
        o_wr_en = 1'b0;
        o_wdata = ~d;
    endtask
    task automatic done();
        @(negedge i_clk_sys);
        o_wr_done = 1'b1;
        @(negedge i_clk_sys);
        o_wr_done = 1'b0;
    endtask
    task automatic look(input logic [7:0] a);
        @(negedge i_clk_sys);
        o_addr = a;
    endtask
    // N low, then N high with M in the same block
    task automatic set_cpu(input logic [8:0] n, input logic [6:0] m);
        put(`OFS_CPU_N_LO, n[7:0]);
        put(`OFS_CPU_N_HI_M, {n[8], m});
        done();
    endtask
    // One byte per block: dividers first, enables in a later block
    task automatic one(input logic [7:0] a, input logic [7:0] d);
        put(a, d);
        done();
    endtask
endmodule // smbus_host_model
`default_nettype wire

/* pll_freq_program_powerdown_test.sv */
// Self-checking bench of the frequency-program and sleep block
`timescale 1ns/1ps
`default_nettype none
module pll_freq_program_powerdown_test;
    logic        i_clk_sys = 1'b0, i_nrst = 1'b0, keep = 1'b0, mgmt = 1'b0, pin_n = 1'b0, cc = 1'b0;
    logic        wr_en, wr_done, o_cpu_prog_active, o_refclk_prog_active, o_glide_to_refclk, o_glide_busy;
    logic        o_power_good_seen, o_clocks_park_low, o_osc_enable, o_cold_reset;
    logic [7:0]  addr, wdata, o_rdata, ctrl, pn, prev = 8'h30, gear_c = 8'h01, gear_r = 8'h01;
    logic [4:0]  straps = 5'h00, o_gear_select;
    logic [16:0] o_cpu_freq_scaled, o_refclk_freq_scaled;
    logic [6:0]  o_cpu_freq_denominator, o_refclk_freq_denominator, m;
    logic [8:0]  n;
    int          n_mismatch = 0, samples_checked = 0, k, pulses;
    integer      seed = 32'h0997;

    smbus_host_model i_host (.i_clk_sys, .o_wr_en(wr_en), .o_wr_done(wr_done), .o_addr(addr), .o_wdata(wdata));
    pll_freq_program_powerdown i_dut (.i_clk_sys, .i_nrst, .i_wr_en(wr_en), .i_addr(addr), .i_wdata(wdata),
        .i_wr_done(wr_done), .o_rdata, .i_keep_config_on_sleep(keep), .i_mgmt_mode(mgmt),
        .i_frequency_select_straps(straps), .i_gear_cpu(gear_c), .i_gear_refclk(gear_r), .i_sleep_pin_n(pin_n),
        .i_processor_clock_complement(cc), .o_gear_select, .o_cpu_freq_scaled, .o_cpu_freq_denominator,
        .o_refclk_freq_scaled, .o_refclk_freq_denominator, .o_cpu_prog_active, .o_refclk_prog_active,
        .o_glide_to_refclk, .o_glide_busy, .o_power_good_seen, .o_clocks_park_low, .o_osc_enable, .o_cold_reset);

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge i_clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_host.look(a);
        cyc(1);
        check("rdata", exp, o_rdata);
    endtask
    function automatic logic [16:0] scaled(input logic [7:0] g, input logic [8:0] v);
        return g * v;
    endfunction

    initial forever #5 i_clk_sys = ~i_clk_sys;
    // Processor complement clock, free running and out of phase with the system clock
    initial begin
        #3;
        forever #62.5 cc = ~cc;
    end
    initial begin
        #900us;
        n_mismatch++;
        close_out();
    end
    initial begin
        cyc(16);
        i_nrst = 1'b1;
        for (k = 8'h0f; k <= 8'h13; k++) rd(8'(k), 8'h00);
        check("cpu enable", 0, o_cpu_prog_active);
        check("pcie enable", 0, o_refclk_prog_active);
        pin_n = 1'b1;
        cyc(8);
        check("power good", 1, o_power_good_seen);
        i_host.one(8'h12, 8'h20);
        cyc(3);
        check("auto owner", 1, o_glide_to_refclk);
        i_host.one(8'h12, 8'h30);
        cyc(3);
        check("auto owner", 0, o_glide_to_refclk);
        for (int it = 0; it < 10; it++) begin
            gear_c = 8'(($random(seed) & 3) + 1);
            gear_r = 8'(($random(seed) & 3) + 1);
            straps = 5'($random(seed));
            n = (it == 9) ? 9'h1ff : 9'($random(seed) & 15);
            m = 7'($random(seed));
            pn = 8'($random(seed) & 15);
            ctrl = (it == 8) ? 8'hc0 : (it == 9) ? 8'hdf : 8'($random(seed));
            i_host.set_cpu(n, m);
            i_host.one(8'h11, pn);
            i_host.put(8'h12, ctrl);
            rd(8'h12, ctrl & 8'hf0);
            check("enable before done", prev[4], o_cpu_prog_active);
            i_host.done();
            cyc(3);
            check("cpu enable", ctrl[4], o_cpu_prog_active);
            check("pcie enable", ctrl[5], o_refclk_prog_active);
            check("cpu m", m, o_cpu_freq_denominator);
            check("pcie m", 7'h01, o_refclk_freq_denominator);
            check("gear select", 17'(straps), 17'(o_gear_select));
            if (ctrl[7]) check("manual owner", ctrl[6], o_glide_to_refclk);
            if (ctrl[7] && ctrl[6] && ctrl[4]) check("cpu jump", scaled(gear_c, n), o_cpu_freq_scaled);
            cyc(4);
            for (k = 0; k < 5000 && o_glide_busy !== 1'b0; k++) cyc(1);
            cyc(1);
            check("glide idle", 0, o_glide_busy);
            if (ctrl[4]) check("cpu freq", scaled(gear_c, n), o_cpu_freq_scaled);
            if (ctrl[5]) check("pcie freq", scaled(gear_r, {1'b0, pn}), o_refclk_freq_scaled);
            prev = ctrl;
        end
        for (int p = 0; p < 3; p++) begin
            i_host.one(8'h12, 8'h10);
            keep = (p == 1);
            mgmt = (p == 2);
            pin_n = 1'b0;
            pulses = 0;
            cyc(4);
            check("early park", 0, o_clocks_park_low);
            for (k = 0; k < 200 && o_osc_enable !== 1'b0; k++) begin
                cyc(1);
                pulses += (o_cold_reset === 1'b1);
            end
            check("osc off", 0, o_osc_enable);
            check("parked", 1, o_clocks_park_low);
            check("cold reset", p == 0, pulses);
            pin_n = 1'b1;
            cyc(8);
            check("woken", 0, o_clocks_park_low);
            rd(8'h12, (p == 0) ? 8'h00 : 8'h10);
        end
        close_out();
    end
endmodule // pll_freq_program_powerdown_test

bind pll_freq_program_powerdown pll_freq_props i_props (.i_clk_sys, .i_nrst, .i_wr_done, .i_keep_config_on_sleep,
    .i_mgmt_mode, .i_sleep_pin_n, .i_addr, .i_frequency_select_straps, .o_rdata, .o_gear_select,
    .o_cpu_freq_denominator, .o_cpu_prog_active, .o_cold_reset, .o_power_good_seen, .o_clocks_park_low,
    .o_osc_enable, .o_glide_busy);
`default_nettype wire
